// File: pkg/sfu_pkg.sv
package sfu_pkg;

  localparam logic [7:0] SFU_OFF_INPUTS = 8'h00;
  localparam logic [7:0] SFU_OFF_MODE = 8'h04;
  localparam logic [7:0] SFU_OFF_SCAN_DIV = 8'h08;
  localparam logic [7:0] SFU_OFF_OPA = 8'h0C;
  localparam logic [7:0] SFU_OFF_OPB = 8'h10;
  localparam logic [7:0] SFU_OFF_PRESET = 8'h14;
  localparam logic [7:0] SFU_OFF_SHIFT = 8'h18;
  localparam logic [7:0] SFU_OFF_COUNT = 8'h1C;
  localparam logic [7:0] SFU_OFF_MOVE = 8'h20;
  localparam logic [7:0] SFU_OFF_ADD = 8'h24;
  localparam logic [7:0] SFU_OFF_SUB = 8'h28;
  localparam logic [7:0] SFU_OFF_INC = 8'h2C;
  localparam logic [7:0] SFU_OFF_FLAGS = 8'h30;
  localparam logic [7:0] SFU_OFF_INT_STAT = 8'h34;
  localparam logic [7:0] SFU_OFF_INT_CLR = 8'h38;
  localparam logic [7:0] SFU_OFF_INT_EN = 8'h3C;

  // Input register bit positions.
  localparam int SFU_IN_PULSE_TRIG = 0;
  localparam int SFU_IN_TOGGLE_TRIG = 1;
  localparam int SFU_IN_SHIFT_EN = 2;
  localparam int SFU_IN_SHIFT_DIR = 3;
  localparam int SFU_IN_FILL = 4;
  localparam int SFU_IN_SHIFT_CLR = 5;
  localparam int SFU_IN_CNT_CLK = 6;
  localparam int SFU_IN_CNT_DIR = 7;
  localparam int SFU_IN_CNT_CLR = 8;
  localparam int SFU_IN_MOVE_EN = 9;
  localparam int SFU_IN_ADD_EN = 10;
  localparam int SFU_IN_SUB_EN = 11;
  localparam int SFU_IN_INC_EN = 12;
  localparam int SFU_IN_W = 13;

  // Mode register bit positions.
  localparam int SFU_MODE_CNT_WIDE = 0;
  localparam int SFU_MODE_ARITH_WIDE = 1;
  localparam int SFU_MODE_PULSE_SHIFT = 2;
  localparam int SFU_MODE_PULSE_MOVE = 3;
  localparam int SFU_MODE_PULSE_ADD = 4;
  localparam int SFU_MODE_PULSE_SUB = 5;
  localparam int SFU_MODE_PULSE_INC = 6;
  localparam int SFU_MODE_W = 7;

  // Interrupt event bit positions.
  localparam int SFU_EV_PULSE = 0;
  localparam int SFU_EV_REACHED = 1;
  localparam int SFU_EV_ADD_OVF = 2;
  localparam int SFU_EV_SUB_OVF = 3;
  localparam int SFU_EV_INC_OVF = 4;
  localparam int SFU_EV_W = 5;

  // Scan step period: 1 us at 40 MHz gives 40 cycles, reload is period minus one.
  localparam int SFU_CLK_MHZ = 40;
  localparam int SFU_SCAN_US = 1;
  localparam logic [15:0] SFU_SCAN_DIV_RST = 16'(SFU_SCAN_US * SFU_CLK_MHZ - 1);

  localparam logic [31:0] SFU_MAX32 = 32'h7FFFFFFF;
  localparam logic [31:0] SFU_MIN32 = 32'h80000000;
  localparam logic [31:0] SFU_MAX16 = 32'h00007FFF;
  localparam logic [31:0] SFU_MIN16 = 32'hFFFF8000;
  localparam logic [31:0] SFU_DNLIM32 = 32'h80000001;
  localparam logic [31:0] SFU_DNLIM16 = 32'hFFFF8001;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sfu_apb_req_s;

endpackage

// File: hw/sfu_top.sv
// Notes on behaviour
// - Pulse coil high one scan on rise.
// - Shifter clear zeroes data and out flag.
// - Shift one bit, direction chooses end.
// - Bit leaving the register goes out.
// - Vacated bit takes the fill-in input.
// - Counter clear holds count at zero.
// - Count clock rise counts up or down.
// - Reached high while count equals preset, one clock late.
// - Up count at maximum wraps to minimum.
// - Down count at limit wraps to maximum.
// - Move copies source into destination.
// - Toggle coil inverts on each trigger rise.
// - Add writes sum with zero/overflow/underflow flags.
// - Arithmetic flags hold until next execution.
// - Subtract writes difference with same flags.
// - Increment wraps at maximum, sets overflow.
// - Units run while enabled, or on rise.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sfu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire sfu_pkg::sfu_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic pulse_coil,
  output logic toggle_coil,
  output logic count_reached,
  output logic shift_out_bit
);
  import sfu_pkg::*;

  logic [SFU_IN_W-1:0] in_reg;
  logic [SFU_IN_W-1:0] prev_reg;
  logic [SFU_MODE_W-1:0] mode_reg;
  logic [15:0] scan_div_reg;
  logic [15:0] div_cnt_reg;
  logic scan_tick;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] preset_reg;
  logic [15:0] shift_reg;
  logic [31:0] count_reg;
  logic [31:0] move_reg;
  logic [31:0] add_reg;
  logic [31:0] sub_reg;
  logic [31:0] inc_reg;
  logic [2:0] add_flags_reg;
  logic [2:0] sub_flags_reg;
  logic inc_ovf_reg;
  logic pulse_reg;
  logic toggle_reg;
  logic reached_reg;
  logic shift_out_reg;
  logic [SFU_EV_W-1:0] int_stat_reg;
  logic [SFU_EV_W-1:0] int_en_reg;
  logic [SFU_EV_W-1:0] events;
  logic [31:0] prdata_reg;
  logic slverr_reg;

  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] wdata;

  logic rise_pulse;
  logic rise_toggle;
  logic rise_cnt;
  logic ex_shift;
  logic ex_move;
  logic ex_add;
  logic ex_sub;
  logic ex_inc;
  logic arith_wide;
  logic cnt_wide;
  logic [32:0] sum_full;
  logic [32:0] diff_full;
  logic [31:0] sum_res;
  logic [31:0] diff_res;
  logic [2:0] add_flags_next;
  logic [2:0] sub_flags_next;
  logic [31:0] count_next;
  logic [31:0] cnt_max;
  logic [31:0] cnt_min;
  logic [31:0] cnt_dnlim;
  logic [31:0] preset_eff;
  logic [31:0] inc_max;
  logic [31:0] inc_min;

  // APB: zero wait states, read data captured in the setup cycle.
  assign wdata = apb_req.pwdata;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & ~slverr_reg;
  assign rd_setup = apb_req.psel & ~apb_req.penable;
  assign pready = apb_req.psel & apb_req.penable;
  assign pslverr = apb_req.psel & apb_req.penable & slverr_reg;
  assign prdata = prdata_reg;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (apb_req.paddr)
      SFU_OFF_INPUTS: rd_mux = 32'(in_reg);
      SFU_OFF_MODE: rd_mux = 32'(mode_reg);
      SFU_OFF_SCAN_DIV: rd_mux = 32'(scan_div_reg);
      SFU_OFF_OPA: rd_mux = opa_reg;
      SFU_OFF_OPB: rd_mux = opb_reg;
      SFU_OFF_PRESET: rd_mux = preset_reg;
      SFU_OFF_SHIFT: rd_mux = 32'(shift_reg);
      SFU_OFF_COUNT: rd_mux = count_reg;
      SFU_OFF_MOVE: rd_mux = move_reg;
      SFU_OFF_ADD: rd_mux = add_reg;
      SFU_OFF_SUB: rd_mux = sub_reg;
      SFU_OFF_INC: rd_mux = inc_reg;
      SFU_OFF_FLAGS: rd_mux = {21'h000000, inc_ovf_reg, sub_flags_reg, add_flags_reg,
                               reached_reg, shift_out_reg, toggle_reg, pulse_reg};
      SFU_OFF_INT_STAT: rd_mux = 32'(int_stat_reg);
      SFU_OFF_INT_CLR: rd_mux = 32'h00000000;
      SFU_OFF_INT_EN: rd_mux = 32'(int_en_reg);
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (rd_setup) begin
      prdata_reg <= apb_req.pwrite ? 32'h00000000 : rd_mux;
      slverr_reg <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reg <= '0;
      mode_reg <= '0;
      scan_div_reg <= SFU_SCAN_DIV_RST;
      opa_reg <= 32'h00000000;
      opb_reg <= 32'h00000000;
      preset_reg <= 32'h00000000;
      int_en_reg <= '0;
    end else if (wr_en) begin
      case (apb_req.paddr)
        SFU_OFF_INPUTS: in_reg <= wdata[SFU_IN_W-1:0];
        SFU_OFF_MODE: mode_reg <= wdata[SFU_MODE_W-1:0];
        SFU_OFF_SCAN_DIV: scan_div_reg <= wdata[15:0];
        SFU_OFF_OPA: opa_reg <= wdata;
        SFU_OFF_OPB: opb_reg <= wdata;
        SFU_OFF_PRESET: preset_reg <= wdata;
        SFU_OFF_INT_EN: int_en_reg <= wdata[SFU_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Scan step divider; a reload below the running count ends the scan at once, not after a wrap.
  assign scan_tick = (div_cnt_reg >= scan_div_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 16'h0000;
    end else if (scan_tick) begin
      div_cnt_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // Input levels seen at the previous scan, for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
    end else if (scan_tick) begin
      prev_reg <= in_reg;
    end
  end

  assign rise_pulse = in_reg[SFU_IN_PULSE_TRIG] & ~prev_reg[SFU_IN_PULSE_TRIG];
  assign rise_toggle = in_reg[SFU_IN_TOGGLE_TRIG] & ~prev_reg[SFU_IN_TOGGLE_TRIG];
  // Counting is edge based, so a clock level that rises and falls between two scan ticks is lost.
  assign rise_cnt = in_reg[SFU_IN_CNT_CLK] & ~prev_reg[SFU_IN_CNT_CLK];

  // Level variant runs every scan, pulse variant only on the enable rise.
  function automatic logic exec_of(input logic en, input logic en_prev, input logic pulse_var);
    exec_of = pulse_var ? (en & ~en_prev) : en;
  endfunction

  always_comb begin
    ex_shift = scan_tick & exec_of(in_reg[SFU_IN_SHIFT_EN], prev_reg[SFU_IN_SHIFT_EN],
                                   mode_reg[SFU_MODE_PULSE_SHIFT]);
    ex_move = scan_tick & exec_of(in_reg[SFU_IN_MOVE_EN], prev_reg[SFU_IN_MOVE_EN],
                                  mode_reg[SFU_MODE_PULSE_MOVE]);
    ex_add = scan_tick & exec_of(in_reg[SFU_IN_ADD_EN], prev_reg[SFU_IN_ADD_EN],
                                 mode_reg[SFU_MODE_PULSE_ADD]);
    ex_sub = scan_tick & exec_of(in_reg[SFU_IN_SUB_EN], prev_reg[SFU_IN_SUB_EN],
                                 mode_reg[SFU_MODE_PULSE_SUB]);
    ex_inc = scan_tick & exec_of(in_reg[SFU_IN_INC_EN], prev_reg[SFU_IN_INC_EN],
                                 mode_reg[SFU_MODE_PULSE_INC]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= 1'b0;
      toggle_reg <= 1'b0;
    end else if (scan_tick) begin
      pulse_reg <= rise_pulse;
      if (rise_toggle) begin
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  // Shifter: direction 1 moves toward the MSB, direction 0 toward the LSB.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 16'h0000;
      shift_out_reg <= 1'b0;
    end else if (in_reg[SFU_IN_SHIFT_CLR]) begin
      shift_reg <= 16'h0000;
      shift_out_reg <= 1'b0;
    end else if (ex_shift) begin
      if (in_reg[SFU_IN_SHIFT_DIR]) begin
        shift_reg <= {shift_reg[14:0], in_reg[SFU_IN_FILL]};
        shift_out_reg <= shift_reg[15];
      end else begin
        shift_reg <= {in_reg[SFU_IN_FILL], shift_reg[15:1]};
        shift_out_reg <= shift_reg[0];
      end
    end
  end

  // Up/down counter, 16-bit values kept sign-extended in 32 bits.
  assign cnt_wide = mode_reg[SFU_MODE_CNT_WIDE];
  assign cnt_max = cnt_wide ? SFU_MAX32 : SFU_MAX16;
  assign cnt_min = cnt_wide ? SFU_MIN32 : SFU_MIN16;
  assign cnt_dnlim = cnt_wide ? SFU_DNLIM32 : SFU_DNLIM16;
  assign preset_eff = cnt_wide ? preset_reg : {{16{preset_reg[15]}}, preset_reg[15:0]};

  always_comb begin
    count_next = count_reg;
    if (in_reg[SFU_IN_CNT_DIR]) begin
      if (count_reg == cnt_max) begin
        count_next = cnt_min;
      end else begin
        count_next = count_reg + 32'h00000001;
      end
    end else begin
      if ($signed(count_reg) <= $signed(cnt_dnlim)) begin
        count_next = cnt_max;
      end else begin
        count_next = count_reg - 32'h00000001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h00000000;
    end else if (in_reg[SFU_IN_CNT_CLR]) begin
      count_reg <= 32'h00000000;
    end else if (scan_tick && rise_cnt) begin
      count_reg <= count_next;
    end
  end

  // Reached follows the count one clock later, so it settles well within a scan.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reached_reg <= 1'b0;
    end else begin
      reached_reg <= (count_reg == preset_eff);
    end
  end

  // Adder and subtractor with signed range checks.
  assign arith_wide = mode_reg[SFU_MODE_ARITH_WIDE];

  always_comb begin
    if (arith_wide) begin
      sum_full = {opa_reg[31], opa_reg} + {opb_reg[31], opb_reg};
      diff_full = {opa_reg[31], opa_reg} - {opb_reg[31], opb_reg};
    end else begin
      sum_full = {{17{opa_reg[15]}}, opa_reg[15:0]} + {{17{opb_reg[15]}}, opb_reg[15:0]};
      diff_full = {{17{opa_reg[15]}}, opa_reg[15:0]} - {{17{opb_reg[15]}}, opb_reg[15:0]};
    end
    sum_res = arith_wide ? sum_full[31:0] : {{16{sum_full[15]}}, sum_full[15:0]};
    diff_res = arith_wide ? diff_full[31:0] : {{16{diff_full[15]}}, diff_full[15:0]};
    add_flags_next[0] = (sum_res == 32'h00000000);
    sub_flags_next[0] = (diff_res == 32'h00000000);
    if (arith_wide) begin
      add_flags_next[1] = ~sum_full[32] & sum_full[31];
      add_flags_next[2] = sum_full[32] & ~sum_full[31];
      sub_flags_next[1] = ~diff_full[32] & diff_full[31];
      sub_flags_next[2] = diff_full[32] & ~diff_full[31];
    end else begin
      add_flags_next[1] = ~sum_full[32] & (sum_full[31:15] != 17'h00000);
      add_flags_next[2] = sum_full[32] & (sum_full[31:15] != 17'h1FFFF);
      sub_flags_next[1] = ~diff_full[32] & (diff_full[31:15] != 17'h00000);
      sub_flags_next[2] = diff_full[32] & (diff_full[31:15] != 17'h1FFFF);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_reg <= 32'h00000000;
    end else if (ex_move) begin
      move_reg <= arith_wide ? opa_reg : {16'h0000, opa_reg[15:0]};
    end
  end

  // Flags change only on an execution, otherwise they keep the last result.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_reg <= 32'h00000000;
      add_flags_reg <= 3'h0;
    end else if (ex_add) begin
      add_reg <= sum_res;
      add_flags_reg <= add_flags_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_reg <= 32'h00000000;
      sub_flags_reg <= 3'h0;
    end else if (ex_sub) begin
      sub_reg <= diff_res;
      sub_flags_reg <= sub_flags_next;
    end
  end

  // Incrementer works on its own register, which software may preload.
  assign inc_max = arith_wide ? SFU_MAX32 : SFU_MAX16;
  assign inc_min = arith_wide ? SFU_MIN32 : SFU_MIN16;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_reg <= 32'h00000000;
      inc_ovf_reg <= 1'b0;
    end else if (wr_en && apb_req.paddr == SFU_OFF_INC) begin
      inc_reg <= wdata;
    end else if (ex_inc) begin
      if (inc_reg == inc_max) begin
        inc_reg <= inc_min;
        inc_ovf_reg <= 1'b1;
      end else begin
        inc_reg <= inc_reg + 32'h00000001;
        inc_ovf_reg <= 1'b0;
      end
    end
  end

  // Interrupt events: a set in the clearing cycle wins so no event is lost.
  always_comb begin
    events = '0;
    events[SFU_EV_PULSE] = scan_tick & rise_pulse;
    events[SFU_EV_REACHED] = (count_reg == preset_eff) & ~reached_reg;
    events[SFU_EV_ADD_OVF] = ex_add & (add_flags_next[1] | add_flags_next[2]);
    events[SFU_EV_SUB_OVF] = ex_sub & (sub_flags_next[1] | sub_flags_next[2]);
    events[SFU_EV_INC_OVF] = ex_inc & (inc_reg == inc_max);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
    end else if (wr_en && apb_req.paddr == SFU_OFF_INT_CLR) begin
      int_stat_reg <= (int_stat_reg & ~wdata[SFU_EV_W-1:0]) | events;
    end else begin
      int_stat_reg <= int_stat_reg | events;
    end
  end

  assign irq = |(int_stat_reg & int_en_reg);
  assign pulse_coil = pulse_reg;
  assign toggle_coil = toggle_reg;
  assign count_reached = reached_reg;
  assign shift_out_bit = shift_out_reg;

endmodule
`default_nettype wire

// File: dv/sfu_apb_mst.sv
`timescale 1ns/1ps
`default_nettype none
module sfu_apb_mst (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var sfu_pkg::sfu_apb_req_s req
);
  import sfu_pkg::*;
  initial req = '0;
  // Signals move only right after a rising edge and hold until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/sfu_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sfu_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire sfu_pkg::sfu_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic pulse_coil,
  input wire logic toggle_coil,
  input wire logic count_reached,
  input wire logic shift_out_bit
);
  import sfu_pkg::*;
  logic acc;
  logic wr;
  logic pz;
  logic mode_wide;
  logic [12:0] in_q;
  logic [15:0] div_q;
  logic [15:0] plen;
  logic [31:0] pre_q;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  // Own copies of the written controls, so the checks never trust the design's registers.
  assign pz = mode_wide ? (pre_q == 32'h0) : (pre_q[15:0] == 16'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q <= '0;
      div_q <= SFU_SCAN_DIV_RST;
      pre_q <= '0;
      mode_wide <= 1'b0;
    end else if (wr) begin
      case (apb_req.paddr)
        SFU_OFF_INPUTS: in_q <= apb_req.pwdata[12:0];
        SFU_OFF_SCAN_DIV: div_q <= apb_req.pwdata[15:0];
        SFU_OFF_PRESET: pre_q <= apb_req.pwdata;
        SFU_OFF_MODE: mode_wide <= apb_req.pwdata[SFU_MODE_CNT_WIDE];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plen <= 16'h0000;
    end else begin
      plen <= pulse_coil ? plen + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pulse_one_scan: assert property ($fell(pulse_coil) |-> plen == div_q + 16'h0001)
    else $error("pulse coil width differs from one scan");
  a_pulse_needs_trig: assert property ($rose(pulse_coil) |-> $past(in_q[SFU_IN_PULSE_TRIG]))
    else $error("pulse coil rose without trigger");
  a_toggle_needs_trig: assert property ($changed(toggle_coil) |-> $past(in_q[1]))
    else $error("toggle coil changed without trigger");
  a_toggle_once_scan: assert property ($changed(toggle_coil) |=> $stable(toggle_coil)[*3])
    else $error("toggle coil changed twice within a scan");
  a_shift_clear_out: assert property (in_q[SFU_IN_SHIFT_CLR][*3] |-> !shift_out_bit)
    else $error("shift out bit not cleared");
  a_count_clear_hold: assert property (in_q[SFU_IN_CNT_CLR][*4] |-> count_reached == pz)
    else $error("count reached wrong while counter cleared");
  a_ready_no_wait: assert property (pready == acc)
    else $error("pready does not follow access phase");
  a_irq_masked: assert property (wr && apb_req.paddr == SFU_OFF_INT_EN &&
    apb_req.pwdata[4:0] == 5'h00 |=> !irq) else $error("irq high with all sources masked");
  a_rdata_held: assert property (acc |=> $stable(prdata))
    else $error("read data changed after access");
  c_pulse: cover property ($fell(pulse_coil));
  c_toggle: cover property ($changed(toggle_coil));
  c_reached: cover property ($rose(count_reached));
endmodule
bind sfu_top sfu_top_chk chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .pulse_coil(pulse_coil),
  .toggle_coil(toggle_coil), .count_reached(count_reached), .shift_out_bit(shift_out_bit));
`default_nettype wire

// File: dv/test_scan_function_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_scan_function_unit;
  import sfu_pkg::*;
  logic pclk;
  logic presetn;
  sfu_apb_req_s apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic pulse_coil;
  logic toggle_coil;
  logic count_reached;
  logic shift_out_bit;
  logic [31:0] q;
  logic e;
  int errors;
  int compares;
  int pulse_cycles;
  logic [31:0] sh_in [6] = '{32'h1C, 32'h1C, 32'h04, 32'h14, 32'h1C, 32'h3C};
  logic [31:0] sh_val [6] = '{32'h1, 32'h3, 32'h1, 32'h8000, 32'h1, 32'h0};
  logic [5:0] sh_out = 6'h1C;
  logic [31:0] ar_md [4] = '{32'h12, 32'h0, 32'h0, 32'h0};
  logic [31:0] ar_a [4] = '{32'h7FFFFFFF, 32'h5, 32'h7FFF, 32'hFFFF8000};
  logic [31:0] ar_b [4] = '{32'h1, 32'hFFFFFFFB, 32'h1, 32'h1};
  logic [31:0] ar_add [4] = '{32'h80000000, 32'h0, 32'hFFFF8000, 32'hFFFF8001};
  logic [31:0] ar_sub [4] = '{32'h7FFFFFFE, 32'hA, 32'h7FFE, 32'h7FFF};
  logic [5:0] ar_fl [4] = '{6'h02, 6'h01, 6'h02, 6'h20};
  logic [31:0] cn_in [6] = '{32'hC0, 32'hC0, 32'hC0, 32'h40, 32'h140, 32'h40};
  logic [31:0] cn_val [6] = '{32'h1, 32'h2, 32'h3, 32'h2, 32'h0, 32'hFFFFFFFF};
  logic [5:0] cn_hit = 6'h0A;
  sfu_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .pulse_coil(pulse_coil),
    .toggle_coil(toggle_coil), .count_reached(count_reached), .shift_out_bit(shift_out_bit));
  sfu_apb_mst m (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req(apb_req));
  // Counted on the falling edge, where the coil output has settled.
  always @(negedge pclk) begin
    if (pulse_coil !== 1'b0) begin
      pulse_cycles <= pulse_cycles + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    m.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    check(q, x);
  endtask
  // Scan divider is set to 3, so one scan is four clocks; ends mid-cycle so outputs are settled.
  task automatic scan(input int n);
    repeat (n * 4) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Every input level is held two scans, so the scan logic never misses an edge.
  task automatic step(input logic [31:0] in);
    wr(SFU_OFF_INPUTS, in);
    scan(2);
    wr(SFU_OFF_INPUTS, 32'h0);
    scan(2);
  endtask
  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    summarize();
  end
  initial begin
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(SFU_OFF_SCAN_DIV, 32'h27);
    wr(SFU_OFF_COUNT, 32'h5);
    rdc(SFU_OFF_COUNT, 32'h0);
    rd(8'h40);
    check({q[30:0], e}, 32'h1);
    rdc(SFU_OFF_INT_CLR, 32'h0);
    wr(SFU_OFF_SCAN_DIV, 32'h3);
    $display("test registers done");
    wr(SFU_OFF_INPUTS, 32'h3);
    scan(2);
    rdc(SFU_OFF_FLAGS, 32'h0A);
    check(pulse_cycles, 32'h4);
    rdc(SFU_OFF_INT_STAT, 32'h3);
    wr(SFU_OFF_INPUTS, 32'h0);
    scan(2);
    check({31'h0, toggle_coil}, 32'h1);
    wr(SFU_OFF_INPUTS, 32'h3);
    scan(2);
    rdc(SFU_OFF_FLAGS, 32'h08);
    $display("test coils done");
    wr(SFU_OFF_INT_EN, 32'h1);
    scan(0);
    check({31'h0, irq}, 32'h1);
    wr(SFU_OFF_INT_EN, 32'h0);
    wr(SFU_OFF_INT_CLR, 32'h3);
    wr(SFU_OFF_INT_EN, 32'h1F);
    scan(0);
    check({31'h0, irq}, 32'h0);
    rdc(SFU_OFF_INT_STAT, 32'h0);
    rdc(SFU_OFF_INT_EN, 32'h1F);
    $display("test interrupts done");
    wr(SFU_OFF_MODE, 32'h4);
    for (int i = 0; i < 6; i++) begin
      step(sh_in[i]);
      rdc(SFU_OFF_SHIFT, sh_val[i]);
      check({31'h0, shift_out_bit}, {31'h0, sh_out[i]});
    end
    $display("test shifter done");
    for (int i = 0; i < 4; i++) begin
      wr(SFU_OFF_MODE, ar_md[i]);
      wr(SFU_OFF_OPA, ar_a[i]);
      wr(SFU_OFF_OPB, ar_b[i]);
      wr(SFU_OFF_INPUTS, 32'hC00);
      scan(2);
      wr(SFU_OFF_INPUTS, 32'h0);
      rdc(SFU_OFF_ADD, ar_add[i]);
      rdc(SFU_OFF_SUB, ar_sub[i]);
      rd(SFU_OFF_FLAGS);
      check((q >> 4) & 32'h3F, {26'h0, ar_fl[i]});
    end
    wr(SFU_OFF_OPA, 32'h0);
    scan(2);
    rd(SFU_OFF_FLAGS);
    check((q >> 4) & 32'h3F, 32'h20);
    $display("test arithmetic done");
    wr(SFU_OFF_OPA, 32'h12345678);
    wr(SFU_OFF_INPUTS, 32'h200);
    scan(2);
    rdc(SFU_OFF_MOVE, 32'h5678);
    wr(SFU_OFF_OPA, 32'h9);
    scan(2);
    rdc(SFU_OFF_MOVE, 32'h9);
    wr(SFU_OFF_MODE, 32'h40);
    wr(SFU_OFF_INC, 32'h7FFE);
    step(32'h1000);
    rdc(SFU_OFF_INC, 32'h7FFF);
    step(32'h1000);
    rdc(SFU_OFF_INC, 32'hFFFF8000);
    rd(SFU_OFF_FLAGS);
    check(q & 32'h400, 32'h400);
    $display("test move and increment done");
    wr(SFU_OFF_MODE, 32'h0);
    wr(SFU_OFF_PRESET, 32'h2);
    for (int i = 0; i < 6; i++) begin
      step(cn_in[i]);
      rdc(SFU_OFF_COUNT, cn_val[i]);
      check({31'h0, count_reached}, {31'h0, cn_hit[i]});
    end
    $display("test counter done");
    summarize();
  end
endmodule
`default_nettype wire
